// ### wdcm_consts.svh
// constants for the windowed watchdog and clock monitor
`ifndef WDCM_CONSTS_SVH
`define WDCM_CONSTS_SVH
`define WIN_MSB           7
`define WIN_LSB           6
`define KEY_MSB           5
`define KEY_LSB           1
`define CM_BIT            0
`define SERVICE_KEY       5'h0c
`define WIN_RESET         2'h3
`define CM_RESET          1'h1
`define LOWER_LIMIT       17'h00800
`define UPPER_BASE        17'h02000
`define HOLD_TICKS        5'h10
`define CLK_PERIOD_NS     4
`define CM_MAX_PERIOD_NS  200000
`define CM_LIMIT_CYCLES   (`CM_MAX_PERIOD_NS / `CLK_PERIOD_NS)
`endif

// ### wdcm_pkg.sv
// types shared by the watchdog files
package wdcm_pkg;
	typedef enum logic [1:0] {ST_RUN, ST_DRIVE, ST_HOLD, ST_WAIT_HIGH} fail_state_t;
endpackage

// ### wd_window_timer.sv
// service window counter measured in idle timer ticks
`timescale 1ns/1ps
`include "wdcm_consts.svh"
module wd_window_timer
	import wdcm_pkg::*;
#(
	parameter int CNT_W = 17
)
(
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// control
	input  wire logic             tick_i,
	input  wire logic             restart_i,
	input  wire logic             run_i,
	input  wire logic [CNT_W-1:0] upper_limit_i,
	// status
	output logic                  early_o,
	output logic                  expired_o
);
	logic [CNT_W-1:0] count;
	wire              advance = run_i & tick_i & ~expired_o;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			count <= '0;
		else if (restart_i)
			count <= '0;
		else if (advance)
			count <= count + 1'b1;
	end

	// lower limit stays fixed whatever window is chosen
	assign early_o   = count < `LOWER_LIMIT;
	assign expired_o = count >= upper_limit_i;

	restart_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		restart_i |=> count == '0 && early_o)
		else $error("window counter not cleared by restart");
endmodule

// ### windowed_watchdog_clock_monitor.sv
// windowed watchdog with instruction clock monitor and fail output
`timescale 1ns/1ps
`include "wdcm_consts.svh"
// Overview of operation
// - watchdog and monitor act only when the option enable is set
// - separate upper and lower limit logic bound the service interval
// - window timing counts idle timer ticks
// - clock monitor flags a missing or very slow instruction clock
// - a service is a write to the service register
// - service value: window select 7:6, key 5:1, monitor select bit 0
// - lower limit is fixed at 2048 ticks
// - window select gives upper limit of 8k, 16k, 32k or 64k ticks
// - ticks are instruction cycles in high speed, else 32 kHz clock
// - key field must equal 01100 for a valid service
// - monitor select bit enables the clock monitor when one
// - monitor never flags while instruction rate is at least 5 kHz
// - only the first keyed write after reset sets window and monitor
// - later writes must match all fields, else error; a match past the lower limit restarts
// - reset arms maximum window and monitor on, detectors running
// - fail pin held low 16 instruction cycles after it reads low
module windowed_watchdog_clock_monitor
	import wdcm_pkg::*;
#(
	parameter int CM_LIMIT = `CM_LIMIT_CYCLES,
	parameter int CM_W     = 16
)
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// configuration
	input  wire logic       wd_option_en_i,
	input  wire logic       high_speed_mode_i,
	// time bases
	input  wire logic       inst_cycle_tick_i,
	input  wire logic       low_speed_clk_i,
	// service register access
	input  wire logic       reg_wr_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	// fail output pin, open drain active low
	input  wire logic       fail_pin_i,
	output logic            fail_pin_o,
	output logic            fail_pin_oe_o
);
	fail_state_t      state;
	fail_state_t      next_state;
	logic [1:0]       win_sel;
	logic             cm_en;
	logic             configured;
	logic             ls_s1;
	logic             ls_s2;
	logic             ls_s3;
	logic             pin_s1;
	logic             pin_s2;
	logic [CM_W-1:0]  cm_gap;
	logic [4:0]       hold_cnt;
	logic             early;
	logic             expired;

	function automatic logic [16:0] upper_of(input logic [1:0] sel);
		upper_of = `UPPER_BASE << sel;
	endfunction

	// slow clock and pin come from outside this clock domain
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ls_s1  <= 1'b0;
			ls_s2  <= 1'b0;
			ls_s3  <= 1'b0;
			pin_s1 <= 1'b1;
			pin_s2 <= 1'b1;
		end
		else
		begin
			ls_s1  <= low_speed_clk_i;
			ls_s2  <= ls_s1;
			ls_s3  <= ls_s2;
			pin_s1 <= fail_pin_i;
			pin_s2 <= pin_s1;
		end
	end

	wire ls_rise   = ls_s2 & ~ls_s3;
	wire idle_tick = high_speed_mode_i ? inst_cycle_tick_i : ls_rise;
	wire pin_low   = ~pin_s2;

	// clock monitor: gap in system clocks since last instruction tick
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			cm_gap <= '0;
		else if (inst_cycle_tick_i)
			cm_gap <= '0;
		else if (cm_gap < CM_LIMIT[CM_W-1:0])
			cm_gap <= cm_gap + 1'b1;
	end

	// a gap of 200 us is exactly 5 kHz, so only slower clocks trip it
	wire cm_slow = cm_gap >= CM_LIMIT[CM_W-1:0];
	wire cm_err  = wd_option_en_i & cm_en & cm_slow;

	// service write decode
	wire [1:0] wr_win = reg_wdata_i[`WIN_MSB:`WIN_LSB];
	wire [4:0] wr_key = reg_wdata_i[`KEY_MSB:`KEY_LSB];
	wire       wr_cm  = reg_wdata_i[`CM_BIT];
	wire       key_ok = wr_key == `SERVICE_KEY;
	wire       all_ok = key_ok & (wr_win == win_sel) & (wr_cm == cm_en);
	// writes during an active fail output are dropped
	wire       wr_accept = wd_option_en_i & reg_wr_i & (state == ST_RUN)
		& ~cm_err;
	// the first service may come inside the lower limit
	wire       svc_ok  = wr_accept & (configured ? (all_ok & ~early)
		: key_ok);
	wire       svc_err = wr_accept & ~svc_ok;
	wire       time_err = (state == ST_RUN) & expired;
	wire       wd_err  = wd_option_en_i & (svc_err | time_err);
	wire       pin_back = (state == ST_WAIT_HIGH) & ~pin_low;
	wire       restart  = svc_ok | pin_back;
	wire       timer_run = wd_option_en_i & (state == ST_RUN);
	wire       hold_done = hold_cnt >= `HOLD_TICKS - 5'h01;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			win_sel    <= `WIN_RESET;
			cm_en      <= `CM_RESET;
			configured <= 1'b0;
		end
		else if (svc_ok & ~configured)
		begin
			win_sel    <= wr_win;
			cm_en      <= wr_cm;
			configured <= 1'b1;
		end
	end

	always_comb
	begin
		next_state = state;
		case (state)
			ST_RUN:
				if (wd_err | cm_err)
					next_state = ST_DRIVE;
			ST_DRIVE:
				if (pin_low)
					next_state = ST_HOLD;
			ST_HOLD:
				if (~cm_err & inst_cycle_tick_i & hold_done)
					next_state = ST_WAIT_HIGH;
			ST_WAIT_HIGH:
				if (~pin_low)
					next_state = ST_RUN;
			default:
				next_state = ST_RUN;
		endcase
		if (~wd_option_en_i)
			next_state = ST_RUN;
	end

	wire next_drive = (next_state == ST_DRIVE) | (next_state == ST_HOLD);

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state         <= ST_RUN;
			hold_cnt      <= 5'h00;
			fail_pin_oe_o <= 1'b0;
			reg_rdata_o   <= 8'h00;
		end
		else
		begin
			state <= next_state;
			// hold count runs on instruction cycles, paused by a clock fault
			if (state != ST_HOLD)
				hold_cnt <= 5'h00;
			else if (inst_cycle_tick_i & ~cm_err & ~hold_done)
				hold_cnt <= hold_cnt + 5'h01;
			fail_pin_oe_o <= next_drive;
			// key never reads back
			reg_rdata_o   <= {win_sel, 5'h00, cm_en};
		end
	end

	assign fail_pin_o = 1'b0;

	wd_window_timer #(
		.CNT_W         (17)
	) u_timer (
		.clk_i         (clk_i),
		.rst_i         (rst_i),
		.tick_i        (idle_tick),
		.restart_i     (restart),
		.run_i         (timer_run),
		.upper_limit_i (upper_of(win_sel)),
		.early_o       (early),
		.expired_o     (expired)
	);

	key_hidden_a: assert property (@(posedge clk_i) disable iff (rst_i)
		reg_rdata_o[`KEY_MSB:`KEY_LSB] == 5'h00)
		else $error("key field visible on read");

	option_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!wd_option_en_i |=> !fail_pin_oe_o)
		else $error("fail output driven with option off");

	bad_key_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_accept && !key_ok |=> fail_pin_oe_o && state == ST_DRIVE)
		else $error("bad key did not raise fail");

	choice_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
		configured |=> $stable(win_sel) && $stable(cm_en) && configured)
		else $error("window or monitor choice changed");

	reset_arm_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!configured |-> win_sel == `WIN_RESET && cm_en == `CM_RESET)
		else $error("not armed at maximum window");

	early_svc_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_accept && configured && all_ok && early |=> fail_pin_oe_o)
		else $error("early service not flagged");

	upper_exp_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wd_option_en_i && state == ST_RUN && expired |=> fail_pin_oe_o)
		else $error("upper limit expiry not flagged");

	ignore_svc_a: assert property (@(posedge clk_i) disable iff (rst_i)
		reg_wr_i && state != ST_RUN |-> !svc_ok && !svc_err)
		else $error("service taken while fail active");

	cm_fast_a: assert property (@(posedge clk_i) disable iff (rst_i)
		inst_cycle_tick_i |=> !cm_err)
		else $error("monitor flagged a running clock");

	hold_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ST_HOLD && next_state == ST_WAIT_HIGH
		|-> hold_cnt == `HOLD_TICKS - 5'h01)
		else $error("fail hold length wrong");
endmodule

// ### fail_pin_model.sv
// pull-up wire with slow falling edge on the fail pin
`timescale 1ns/1ps
module fail_pin_model
#(
	parameter int FALL_CYC = 3
)
(
	// clock
	input  wire logic clk_i,
	// drive from the device
	input  wire logic drv_i,
	input  wire logic oe_i,
	// sensed level
	output logic      pin_o
);
	logic [7:0] low_sr;
	// slow falling edge, so the hold is timed from the sensed low
	always_ff @(posedge clk_i)
	begin
		low_sr <= {low_sr[6:0], oe_i & ~drv_i};
	end
	assign pin_o = ~(low_sr[FALL_CYC-1] & oe_i); // pull-up
endmodule

// ### tb_top.sv
// self-checking bench for the watchdog and clock monitor
`timescale 1ns/1ps
module tb_top;
	logic       clk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic       opt = 1'b1;
	logic       tick = 1'b1;
	logic       hs = 1'b1;
	logic       lsclk = 1'b0;
	logic       wr = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic       pin;
	logic       drv;
	logic       oe;
	int         bad_count = 0;
	int         n_tests = 0;
	logic [7:0] bad_vals [3] = '{8'h59, 8'h18, 8'h1b};
	always #2 clk_i = ~clk_i;
	// slow clock toggles off the system clock's rising edge
	always #4 lsclk = ~lsclk;
	windowed_watchdog_clock_monitor #(.CM_LIMIT(64)) uut (
		.clk_i             (clk_i),
		.rst_i             (rst_i),
		.wd_option_en_i    (opt),
		.high_speed_mode_i (hs),
		.inst_cycle_tick_i (tick),
		.low_speed_clk_i   (lsclk),
		.reg_wr_i          (wr),
		.reg_wdata_i       (wdata),
		.reg_rdata_o       (rdata),
		.fail_pin_i        (pin),
		.fail_pin_o        (drv),
		.fail_pin_oe_o     (oe)
	);
	fail_pin_model #(.FALL_CYC(3)) pin_model (
		.clk_i (clk_i),
		.drv_i (drv),
		.oe_i  (oe),
		.pin_o (pin)
	);
	task automatic check(input string nm, input logic [7:0] e, got);
		n_tests++;
		if (got !== e)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, got);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wr_reg(input logic [7:0] d);
		wr <= 1'b1;
		wdata <= d;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	// sample oe off the edge, then resync to a rising edge
	task automatic oe_is(input logic v);
		@(negedge clk_i);
		check("fail_oe", {7'h0, v}, {7'h0, oe});
		@(posedge clk_i);
	endtask
	// bounded wait sampled off the edge; an exhausted bound ends the run
	task automatic wait_oe(input logic v, input int n);
		int i;
		i = 0;
		@(negedge clk_i);
		while (i < n && oe !== v)
		begin
			@(negedge clk_i);
			i++;
		end
		check("fail_oe_wait", {7'h0, v}, {7'h0, oe});
		if (oe !== v)
			results();
		else
			@(posedge clk_i);
	endtask
	// error seen, held past the sensed low, then released
	task automatic fail_cycle();
		wait_oe(1'b1, 3);
		wr_reg(8'h19);
		cyc(17);
		oe_is(1'b1);
		wait_oe(1'b0, 30);
		cyc(8);
	endtask
	initial
	begin
		cyc(20);
		rst_i <= 1'b0;
		// readback is registered, so it refreshes one edge after release
		@(posedge clk_i);
		@(negedge clk_i);
		check("rdata_reset", 8'hc1, rdata);
		check("fail_drive", 8'h00, {7'h0, drv});
		@(posedge clk_i);
		wr_reg(8'h19);
		cyc(2);
		@(negedge clk_i);
		check("rdata_config", 8'h01, rdata);
		oe_is(1'b0);
		$display("first service test done");
		cyc(2100);
		wr_reg(8'h19);
		oe_is(1'b0);
		cyc(1);
		wr_reg(8'h19);
		fail_cycle();
		$display("early service test done");
		foreach (bad_vals[k])
		begin
			cyc(2100);
			wr_reg(bad_vals[k]);
			fail_cycle();
		end
		$display("mismatch test done");
		cyc(2100);
		wr_reg(8'h19);
		// expiry lands 8193 edges after the service edge
		cyc(8190);
		oe_is(1'b0);
		wait_oe(1'b1, 4);
		wait_oe(1'b0, 40);
		cyc(8);
		$display("upper limit test done");
		tick <= 1'b0;
		cyc(40);
		oe_is(1'b0);
		wait_oe(1'b1, 60);
		tick <= 1'b1;
		wait_oe(1'b0, 60);
		cyc(8);
		$display("clock monitor test done");
		// slow clock ticks at half rate, so this wait is now too early
		hs <= 1'b0;
		cyc(2100);
		wr_reg(8'h19);
		fail_cycle();
		cyc(4200);
		wr_reg(8'h19);
		oe_is(1'b0);
		$display("low speed test done");
		opt <= 1'b0;
		wr_reg(8'h00);
		cyc(4);
		oe_is(1'b0);
		$display("option off test done");
		results();
	end
endmodule
